/* core/fcf_consts.svh */
/*
  Timing counts and field sizes for the forwarded clock and
  framing block. Assumes a 100 MHz core clock; include by bare name.
*/
`ifndef FCF_CONSTS_SVH
`define FCF_CONSTS_SVH

`define FCF_CLK_NS 10
`define FCF_BIT_TIME_NS 80
`define FCF_BIT_CYC ((`FCF_BIT_TIME_NS + `FCF_CLK_NS - 1) / `FCF_CLK_NS)
`define FCF_BIT_CNT_W 4
`define FCF_WAKE_CYC 8
`define FCF_WAKE_W 4
`define FCF_BEATS 4
`define FCF_MUX_W 2
`define FCF_LAST_BEAT 2'h3
`define FCF_FBITS_W 5
`define FCF_BUF_DEPTH 2

`endif

/* core/fcf_pkg.sv */
/*
  Types shared by the forwarded clock and framing block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fcf_pkg;

  typedef logic [7:0] fcf_beat_t;

  // One four-beat command/address transfer; b0 travels first.
  typedef struct packed {
    fcf_beat_t b3;
    fcf_beat_t b2;
    fcf_beat_t b1;
    fcf_beat_t b0;
  } fcf_word_t;

  // Frame-ratio selector: a framing period holds 2, 4, 8 or 16 bit times.
  typedef enum logic [1:0] {
    FCF_SEL_1X,
    FCF_SEL_2X,
    FCF_SEL_4X,
    FCF_SEL_8X
  } fcf_sel_t;

endpackage : fcf_pkg

/* core/fcf_buf.sv */
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock and an asynchronous active-low reset; outputs are flops.
*/
`timescale 1ns/1ns
`default_nettype none

module fcf_buf import fcf_pkg::*; (
  input wire logic i_clk,         // Core clock.
  input wire logic i_rst_b,       // Asynchronous reset, active low.
  input wire logic i_valid,       // Word offered.
  input wire fcf_word_t i_data,   // Word offered.
  output logic o_ready,           // Room for a word.
  output logic o_valid,           // Head word present.
  output fcf_word_t o_data,       // Head word.
  input wire logic i_ready        // Consumer takes the head word.
);

  logic v0_q, v1_q, v0_d, v1_d, rdy_q;
  fcf_word_t d0_q, d1_q, d0_d, d1_d;

  wire logic pop = v0_q & i_ready;
  wire logic push = i_valid & rdy_q;

  always_comb begin
    v0_d = v0_q;
    v1_d = v1_q;
    d0_d = d0_q;
    d1_d = d1_q;
    if (pop) begin
      v0_d = v1_q;
      d0_d = d1_q;
      v1_d = 1'b0;
    end
    if (push) begin
      if (!v0_d) begin
        v0_d = 1'b1;
        d0_d = i_data;
      end else begin
        v1_d = 1'b1;
        d1_d = i_data;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      v0_q <= 1'b0;
      v1_q <= 1'b0;
      d0_q <= '0;
      d1_q <= '0;
      rdy_q <= 1'b0;
    end else begin
      v0_q <= v0_d;
      v1_q <= v1_d;
      d0_q <= d0_d;
      d1_q <= d1_d;
      rdy_q <= ~v1_d;
    end
  end

  assign o_ready = rdy_q;
  assign o_valid = v0_q;
  assign o_data = d0_q;

endmodule : fcf_buf

`default_nettype wire

/* core/fcf_top.sv */
/*
  Forwarded clock and framing logic for the device end of a
  source-synchronous link: transmit with a locally forwarded clock, frame
  alignment, interface reset sequencing and double-edge receive.
  Assumes the far end forwards i_link_clk with its data and stops it
  between frames, and that framing clock and interface reset are pins.
*/
// What this block does
// - Sender forwards a clock beside its data, period two bit times.
// - While running, forwarded clock is 50% duty and every data change coincides with a clock edge.
// - Frame-ratio selector fixes bit times per framing period; 2X means four.
// - Transmit transfers start only at frame boundaries; the receive path does not check framing.
// - Framing period may be shorter, equal or longer than one transfer.
// - Framing clock edges are the reference for where transmissions begin.
// - Interface reset stops forwarded clocks, presets counters, then restarts.
// - Mux counter clears on interface reset and steps on each forwarded clock edge that sends a beat.
// - Receivers capture on both forwarded clock edges; bit times match.
`timescale 1ns/1ns
`default_nettype none
`include "fcf_consts.svh"

module fcf_top import fcf_pkg::*; (
  input wire logic i_clk,           // Core clock, 100 MHz.
  input wire logic i_rst_b,         // Asynchronous reset, active low.
  input wire logic i_frame_clk,     // Framing clock pin.
  input wire logic i_if_rst,        // Interface reset pin, active high.
  input wire fcf_sel_t i_frame_sel, // Frame-ratio selector.
  input wire logic i_tx_valid,      // Transfer offered for sending.
  input wire fcf_word_t i_tx_word,  // Transfer to send.
  output logic o_tx_ready,          // Transfer accepted when valid.
  output logic o_fwd_clk,           // Forwarded clock out.
  output fcf_beat_t o_tx_data,      // Link data out.
  output logic o_tx_beat,           // Link data carries a beat.
  input wire logic i_link_clk,      // Forwarded clock from far end.
  input wire fcf_beat_t i_rx_data,  // Link data in.
  input wire logic i_rx_valid,      // Link data in carries a beat.
  output logic o_rx_valid,          // Received transfer present.
  output fcf_word_t o_rx_word,      // Received transfer.
  input wire logic i_rx_ready,      // Consumer takes received transfer.
  output logic o_rx_overrun,        // A received transfer was lost.
  output logic o_link_up            // Forwarded clock running.
);

  typedef enum logic [1:0] {ST_RESET, ST_WAKE, ST_RUN} fcf_state_t;

  localparam logic [`FCF_BIT_CNT_W-1:0] BIT_LAST =
    `FCF_BIT_CNT_W'(`FCF_BIT_CYC - 1);
  localparam logic [`FCF_WAKE_W-1:0] WAKE_LAST =
    `FCF_WAKE_W'(`FCF_WAKE_CYC - 1);

  function automatic fcf_beat_t beat_of(input fcf_word_t w,
                                        input logic [1:0] idx);
    beat_of = w[idx*8 +: 8];
  endfunction : beat_of

  // Pin synchronisers; the first flop of each feeds only the second.
  logic fr_s1_q, fr_s2_q, fr_s3_q, ir_s1_q, ir_s2_q;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fr_s1_q <= 1'b0;
      fr_s2_q <= 1'b0;
      fr_s3_q <= 1'b0;
      ir_s1_q <= 1'b1;
      ir_s2_q <= 1'b1;
    end else begin
      fr_s1_q <= i_frame_clk;
      fr_s2_q <= fr_s1_q;
      fr_s3_q <= fr_s2_q;
      ir_s1_q <= i_if_rst;
      ir_s2_q <= ir_s1_q;
    end
  end

  wire logic frame_edge = fr_s2_q ^ fr_s3_q;

  // Interface reset sequencing.
  fcf_state_t st_q, st_d;
  logic [`FCF_WAKE_W-1:0] wake_q;
  fcf_sel_t sel_q;
  logic link_q;
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_RESET: if (!ir_s2_q) st_d = ST_WAKE;
      ST_WAKE: if (ir_s2_q) st_d = ST_RESET;
               else if (wake_q == WAKE_LAST) st_d = ST_RUN;
      ST_RUN: if (ir_s2_q) st_d = ST_RESET;
    endcase
  end
  wire logic run = (st_q == ST_RUN);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= ST_RESET;
      wake_q <= '0;
      sel_q <= FCF_SEL_1X;
      link_q <= 1'b0;
    end else begin
      st_q <= st_d;
      link_q <= (st_d == ST_RUN);
      wake_q <= (st_q == ST_WAKE) ? wake_q + 1'b1 : '0;
      if (ir_s2_q) sel_q <= i_frame_sel;
    end
  end

  // Bit timer and frame boundary tracking.
  logic [`FCF_BIT_CNT_W-1:0] bt_q;
  logic [`FCF_FBITS_W-1:0] fbits_q;
  logic fpend_q;
  wire logic tick = run & (bt_q == BIT_LAST);
  wire logic [`FCF_FBITS_W-1:0] half_last =
    (`FCF_FBITS_W'(1) << sel_q) - `FCF_FBITS_W'(1);
  wire logic boundary =
    tick & (fpend_q | frame_edge | (fbits_q == half_last));

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bt_q <= '0;
      fbits_q <= '0;
      fpend_q <= 1'b0;
    end else begin
      bt_q <= (!run || tick) ? '0 : bt_q + 1'b1;
      fbits_q <= !run ? '0 : boundary ? '0 : tick ? fbits_q + 1'b1 : fbits_q;
      fpend_q <= run & ~tick & (frame_edge | fpend_q);
    end
  end

  // Transmit path with output mux counter.
  logic have_q, send_q, rdy_q, fclk_q, beat_q;
  logic [`FCF_MUX_W-1:0] mux_q;
  fcf_word_t txw_q;
  fcf_beat_t txd_q;
  wire logic accept = i_tx_valid & rdy_q;
  wire logic emit = tick & (send_q | (boundary & have_q));
  wire logic last = emit & (mux_q == `FCF_LAST_BEAT);
  wire logic have_d = run & (accept | (have_q & ~last));

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      have_q <= 1'b0;
      send_q <= 1'b0;
      rdy_q <= 1'b0;
      fclk_q <= 1'b0;
      beat_q <= 1'b0;
      mux_q <= '0;
      txw_q <= '0;
      txd_q <= '0;
    end else begin
      have_q <= have_d;
      rdy_q <= run & ~have_d;
      if (accept) txw_q <= i_tx_word;
      if (!run) begin
        send_q <= 1'b0;
        fclk_q <= 1'b0;
        mux_q <= '0;
        beat_q <= 1'b0;
        txd_q <= '0;
      end else if (tick) begin
        fclk_q <= ~fclk_q;
        send_q <= emit & ~last;
        beat_q <= emit;
        txd_q <= emit ? beat_of(txw_q, mux_q) : '0;
        if (emit) mux_q <= mux_q + 1'b1;
      end
    end
  end

  // Link-domain capture on both edges of the far end's forwarded clock.
  fcf_beat_t lk_pos_q;
  logic lk_posv_q, lk_half_q, lk_tog_q;
  logic [15:0] lk_lo_q;
  fcf_word_t lk_word_q;
  always_ff @(posedge i_link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lk_pos_q <= '0;
      lk_posv_q <= 1'b0;
    end else begin
      lk_pos_q <= i_rx_data;
      lk_posv_q <= i_rx_valid;
    end
  end

  always_ff @(negedge i_link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lk_half_q <= 1'b0;
      lk_tog_q <= 1'b0;
      lk_lo_q <= '0;
      lk_word_q <= '0;
    end else if (i_rx_valid && lk_posv_q) begin
      lk_half_q <= ~lk_half_q;
      if (!lk_half_q) begin
        lk_lo_q <= {i_rx_data, lk_pos_q};
      end else begin
        lk_word_q <= {i_rx_data, lk_pos_q, lk_lo_q};
        lk_tog_q <= ~lk_tog_q;
      end
    end else begin
      lk_half_q <= 1'b0;
    end
  end

  // Toggle crossing into the core domain; the word is stable meanwhile.
  logic tg_s1_q, tg_s2_q, tg_seen_q, pend_q, ovr_q;
  fcf_word_t pend_w_q;
  logic buf_ready;
  wire logic rx_new = tg_s2_q ^ tg_seen_q;
  wire logic push = pend_q & buf_ready;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tg_s1_q <= 1'b0;
      tg_s2_q <= 1'b0;
      tg_seen_q <= 1'b0;
      pend_q <= 1'b0;
      pend_w_q <= '0;
      ovr_q <= 1'b0;
    end else begin
      tg_s1_q <= lk_tog_q;
      tg_s2_q <= tg_s1_q;
      tg_seen_q <= tg_s2_q;
      if (rx_new) begin
        pend_q <= 1'b1;
        pend_w_q <= lk_word_q;
      end else if (push) begin
        pend_q <= 1'b0;
      end
      ovr_q <= (rx_new & pend_q & ~push) | (ovr_q & ~ir_s2_q);
    end
  end

  fcf_buf u_buf (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_valid(pend_q),
    .i_data(pend_w_q),
    .o_ready(buf_ready),
    .o_valid(o_rx_valid),
    .o_data(o_rx_word),
    .i_ready(i_rx_ready)
  );

  assign o_tx_ready = rdy_q;
  assign o_fwd_clk = fclk_q;
  assign o_tx_data = txd_q;
  assign o_tx_beat = beat_q;
  assign o_rx_overrun = ovr_q;
  assign o_link_up = link_q;

endmodule : fcf_top

`default_nettype wire

/* verif/fcf_top_assertions.sv */
/*
  Checker for the forwarded clock and framing block, bound to fcf_top.
  Assumes the core clock domain and its active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
module fcf_top_chk import fcf_pkg::*; (
  input wire logic i_clk,        // Core clock.
  input wire logic i_rst_b,      // Reset, active low.
  input wire logic i_if_rst,     // Interface reset pin.
  input wire logic i_tx_valid,   // Transfer offered.
  input wire logic o_tx_ready,   // Transfer taken.
  input wire logic o_fwd_clk,    // Forwarded clock.
  input wire fcf_beat_t o_tx_data, // Link data out.
  input wire logic o_tx_beat,    // Beat marker.
  input wire logic o_rx_valid,   // Received word present.
  input wire fcf_word_t o_rx_word, // Received word.
  input wire logic i_rx_ready,   // Consumer takes word.
  input wire logic o_link_up     // Link running.
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  fwd_idle_a: assert property (
    !o_link_up ##1 !o_link_up |-> !o_fwd_clk)
    else $error("forwarded clock runs while link down");
  ifrst_stop_a: assert property (
    i_if_rst [*4] |-> !o_link_up)
    else $error("link stays up in interface reset");
  wake_gap_a: assert property (
    $rose(o_link_up) |-> !$past(i_if_rst, 9))
    else $error("link up too soon after interface reset");
  ready_up_a: assert property (
    $rose(o_link_up) |=> o_tx_ready)
    else $error("ready not raised after link up");
  fwd_duty_a: assert property (
    $changed(o_fwd_clk) && o_link_up |=>
    ($stable(o_fwd_clk) || !o_link_up) [*7])
    else $error("forwarded clock level not eight cycles");
  data_edge_a: assert property (
    $changed(o_tx_data) && o_link_up |-> $changed(o_fwd_clk))
    else $error("data changed off a clock edge");
  beat_start_a: assert property (
    $rose(o_tx_beat) |-> $changed(o_fwd_clk))
    else $error("transfer began off a clock edge");
  beat_len_a: assert property (
    $rose(o_tx_beat) |-> o_tx_beat [*8] ##24 o_tx_beat)
    else $error("transfer shorter than four bit times");
  tx_take_a: assert property (
    i_tx_valid && o_tx_ready |=> !o_tx_ready)
    else $error("ready held after a word was taken");
  rx_hold_a: assert property (
    o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_word))
    else $error("received word dropped before taken");
  idle_data_a: assert property (
    !o_tx_beat |-> o_tx_data == 8'h00)
    else $error("link data not zero between beats");
endmodule : fcf_top_chk
bind fcf_top fcf_top_chk chk_u (.i_clk(i_clk), .i_rst_b(i_rst_b),
  .i_if_rst(i_if_rst), .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready),
  .o_fwd_clk(o_fwd_clk), .o_tx_data(o_tx_data), .o_tx_beat(o_tx_beat),
  .o_rx_valid(o_rx_valid), .o_rx_word(o_rx_word), .i_rx_ready(i_rx_ready),
  .o_link_up(o_link_up));
`default_nettype wire

/* verif/fcf_link_partner.sv */
/*
  Far-end model: sends four-beat words with its own forwarded clock.
  Assumes the framing clock is shared with the device.
*/
`timescale 1ns/1ns
`default_nettype none
module fcf_link_partner import fcf_pkg::*; (
  input wire logic i_frame_clk, // Framing clock.
  output logic o_link_clk,      // Forwarded clock to device.
  output fcf_beat_t o_data,     // Link data.
  output logic o_valid          // Beat present.
);
  initial begin
    o_link_clk = 1'b0;
    o_data = 8'h00;
    o_valid = 1'b0;
    #20 o_link_clk = 1'b1;
    #80 o_link_clk = 1'b0;
  end
  task automatic send_word(input fcf_word_t w);
    @(i_frame_clk);
    for (int i = 0; i < 4; i++) begin
      o_data = w[i*8 +: 8];
      o_valid = 1'b1;
      // Edge sits mid-beat in place of the clock offset delay.
      #40 o_link_clk = ~o_link_clk;
      #40;
    end
    o_data = ~o_data;
    o_valid = 1'b0;
  endtask : send_word
endmodule : fcf_link_partner
`default_nettype wire

/* verif/tb_forwarded_clock_framing.sv */
/*
  Self-checking bench for fcf_top with a far-end model.
  Assumes a 100 MHz core clock and a 160 ns link clock.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_forwarded_clock_framing import fcf_pkg::*;;
  logic clk, rst_b, frame_clk, if_rst, tx_valid, tx_ready, fwd_clk, tx_beat;
  logic link_clk, rx_valid, rxo_valid, rx_ready, overrun, link_up, fwd_prev;
  fcf_sel_t frame_sel;
  fcf_word_t tx_word, rx_word, w, v;
  fcf_beat_t tx_data, rx_data;
  int error_cnt, check_count, cyc;
  int fhp = 8;
  logic [31:0] seed;
  fcf_beat_t tx_q[$];
  fcf_word_t rx_q[$];
  fcf_top dut_u (.i_clk(clk), .i_rst_b(rst_b), .i_frame_clk(frame_clk),
    .i_if_rst(if_rst), .i_frame_sel(frame_sel), .i_tx_valid(tx_valid),
    .i_tx_word(tx_word), .o_tx_ready(tx_ready), .o_fwd_clk(fwd_clk),
    .o_tx_data(tx_data), .o_tx_beat(tx_beat), .i_link_clk(link_clk),
    .i_rx_data(rx_data), .i_rx_valid(rx_valid), .o_rx_valid(rxo_valid),
    .o_rx_word(rx_word), .i_rx_ready(rx_ready), .o_rx_overrun(overrun),
    .o_link_up(link_up));
  fcf_link_partner partner_u (.i_frame_clk(frame_clk), .o_link_clk(link_clk),
    .o_data(rx_data), .o_valid(rx_valid));
  always #5 clk = ~clk;
  always begin
    repeat (fhp) @(posedge clk);
    frame_clk <= ~frame_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task chk(input string name, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task final_report();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  task send_tx(input fcf_word_t x);
    for (int i = 0; i < 4; i++) tx_q.push_back(x[i*8 +: 8]);
    @(posedge clk);
    tx_valid <= 1'b1;
    tx_word <= x;
    do @(posedge clk); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
  endtask : send_tx
  task if_up(input fcf_sel_t s);
    if_rst <= 1'b1;
    frame_sel <= s;
    repeat (6) @(posedge clk);
    chk("fwd_clk", 32'(fwd_clk), 0);
    if_rst <= 1'b0;
    do @(posedge clk); while (link_up !== 1'b1);
    frame_sel <= fcf_sel_t'(seed[1:0]);
  endtask : if_up
  always @(posedge clk) begin
    if (tx_beat === 1'b1 && fwd_clk !== fwd_prev) begin
      chk("tx_data", 32'(tx_data), 32'(tx_q.pop_front()));
    end
    fwd_prev = fwd_clk;
    if (rxo_valid === 1'b1 && rx_ready === 1'b1) begin
      chk("rx_word", rx_word, rx_q.pop_front());
    end
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    frame_clk = 1'b0;
    if_rst = 1'b1;
    frame_sel = FCF_SEL_1X;
    tx_valid = 1'b0;
    tx_word = '0;
    rx_ready = 1'b1;
    fwd_prev = 1'b0;
    seed = 32'h00006C33;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      w = rnd();
      v = rnd();
      fhp = 4 << s;
      if_up(fcf_sel_t'(s));
      rx_q.push_back(v);
      fork
        begin
          send_tx(w);
          send_tx(~w);
        end
        partner_u.send_word(v);
      join
      while (tx_q.size() != 0) @(posedge clk);
      @(posedge clk);
    end
    rx_ready <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      rx_q.push_back(rnd());
      partner_u.send_word(seed);
    end
    repeat (10) @(posedge clk);
    chk("rx_valid", 32'(rxo_valid), 1);
    rx_ready <= 1'b1;
    repeat (50) @(posedge clk);
    chk("overrun", 32'(overrun), 0);
    chk("rx_left", rx_q.size(), 0);
    chk("tx_left", tx_q.size(), 0);
    final_report();
  end
endmodule : tb_forwarded_clock_framing
`default_nettype wire
